//--- core/ack_sync.sv
// Three-stage synchroniser for the acknowledge pair
`timescale 1ns/1ps
`default_nettype none
module ack_sync
   import bus_sizing_pkg::*;
(
   // Clock and reset
   input  wire logic       clock_in,
   input  wire logic       rst_b_in,
   // Raw pins and agreed result
   input  wire logic [1:0] raw_in,
   output logic      [1:0] stable_out
);
   typedef struct packed {
      logic [1:0] s1;   // First stage, read only by s2
      logic [1:0] s2;   // Second stage
      logic [1:0] s3;   // Third stage
      logic [1:0] agreed; // Value once s2 and s3 agree
   } sync_t;
   sync_t st_r;   // Registered state
   sync_t st_nxt; // Next state

   // Shift and accept a change only when two late stages match
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = raw_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      if (st_r.s2 == st_r.s3) begin
         st_nxt.agreed = st_r.s3;
      end
   end

   // Idle is negated, so reset to all ones
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r <= '{ACK_NONE, ACK_NONE, ACK_NONE, ACK_NONE};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign stable_out = st_r.agreed;
endmodule
`default_nettype wire

//--- core/bus_sizing_master.sv
// Operand steering and dynamic bus sizing master
`timescale 1ns/1ps
`default_nettype none
module bus_sizing_master
   import bus_sizing_pkg::*;
(
   // Clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_b_in,
   // Core request side
   input  wire logic        req_valid_in,
   output logic             req_ready_out,
   input  wire logic [23:0] req_addr_in,
   input  wire logic [1:0]  req_size_in,
   input  wire logic        req_write_in,
   input  wire logic [2:0]  req_space_in,
   input  wire logic [31:0] req_wdata_in,
   output logic             done_out,
   output logic [31:0]      rdata_out,
   // External bus
   output logic [23:0]      addr_out,
   output logic [1:0]       transfer_size_code_out,
   output logic [2:0]       access_space_code_out,
   output logic             read_not_write_out,
   output logic             address_strobe_b_out,
   output logic             data_strobe_b_out,
   output logic [15:0]      data_out,
   output logic             data_oe_out,
   input  wire logic [15:0] data_in,
   input  wire logic [1:0]  port_width_ack_pair_in
);
   typedef struct packed {
      bus_state_t  state;  // Sequencer state
      logic [23:0] addr;   // Current byte address
      logic [2:0]  left;   // Bytes still to move
      logic        write;  // Direction of operation
      logic [2:0]  space;  // Access space
      logic [31:0] wbuf;   // Write bytes, next one in [31:24]
      logic [31:0] rbuf;   // Read bytes gathered, shifted in
      logic        done;   // One-cycle completion pulse
      logic [31:0] rdata;  // Result word
      logic        split;  // Misaligned long, second word pending
   } mst_t;
   mst_t st_r;   // Registered state
   mst_t st_nxt; // Next state

   // Flow of one request: the request is taken while idle, then each bus
   // cycle runs address set-up, a strobed wait that lasts until the
   // synchronised acknowledge shows, and an end phase with the strobes
   // negated. The end phase also waits for the partner to negate its
   // acknowledge, so a slow release is never mistaken for the answer to
   // the next cycle. The remaining-byte count picks the size code of each
   // cycle, and the width of the answering port picks how many bytes the
   // cycle moved. Write bytes sit left-justified in a shift buffer so the
   // next byte to go out is always in the top byte; read bytes shift in
   // from the bottom so the result ends up right-justified.

   logic [1:0] ack_sync; // Synchronised acknowledge pair

   // Acknowledge pins come from the partner, so synchronise them
   // Three flops plus an agreement stage: an answer is seen about
   // four cycles after it appears on the pins
   ack_sync u_ack_sync (
      .clock_in   (clock_in),
      .rst_b_in   (rst_b_in),
      .raw_in     (port_width_ack_pair_in),
      .stable_out (ack_sync)
   );

   // Size code for a byte count; three is only reached mid-transfer
   function automatic logic [1:0] size_of(input logic [2:0] n);
      case (n)
         3'h1:    size_of = SIZE_BYTE;
         3'h2:    size_of = SIZE_WORD;
         3'h3:    size_of = SIZE_THREE; // R16
         // Four or more bytes left codes as a long word
         default: size_of = SIZE_LONG;
      endcase
   endfunction

   // Byte count for an initial request size
   function automatic logic [2:0] count_of(input logic [1:0] s);
      case (s)
         SIZE_BYTE: count_of = 3'h1;
         SIZE_WORD: count_of = 3'h2;
         // Requests never start as three bytes
         default:   count_of = 3'h4;
      endcase
   endfunction

   // Per-cycle decode, all combinational from registered state
   logic       half_ack; // Halfword acknowledge seen
   logic       byte_ack; // Byte acknowledge seen
   logic       any_ack;  // Either line asserted
   logic [2:0] moved;    // Bytes taken this cycle
   logic [2:0] cyc_cnt;  // Bytes requested this cycle

   // Decode the acknowledge pair, active low lines
   always_comb begin
      half_ack = ~ack_sync[1]; // R21
      byte_ack = ~ack_sync[0]; // R21
      any_ack  = half_ack | byte_ack;
      // A misaligned long is issued as two misaligned words. While the
      // first word is open only its own bytes count, so after the odd
      // first byte the next cycle is a lone even byte.
      if (st_r.split && st_r.left > 3'h2) begin
         cyc_cnt = st_r.left - 3'h2; // R18
      end else begin
         cyc_cnt = st_r.left;
      end
      if (half_ack && !st_r.addr[0] && cyc_cnt >= 3'h2) begin
         moved = 3'h2; // R14
      end else begin
         moved = 3'h1; // R12 R17
      end
   end

   // Sequencer: steer bytes, sample acknowledge, split cycles
   always_comb begin
      st_nxt      = st_r;
      st_nxt.done = 1'b0;
      case (st_r.state)
         // Take a request only while idle; ready is high exactly then
         ST_IDLE: begin
            if (req_valid_in) begin
               st_nxt.state = ST_ADDR; // R2
               st_nxt.addr  = req_addr_in;
               st_nxt.left  = count_of(req_size_in);
               st_nxt.write = req_write_in;
               st_nxt.space = req_space_in;
               st_nxt.rbuf  = DATA_RST;
               st_nxt.split = (req_size_in == SIZE_LONG) && req_addr_in[0];
               // Left-justify so the first byte is most significant
               case (req_size_in)
                  SIZE_BYTE: st_nxt.wbuf = {req_wdata_in[7:0], 24'h000000};
                  SIZE_WORD: st_nxt.wbuf = {req_wdata_in[15:0], 16'h0000};
                  default:   st_nxt.wbuf = req_wdata_in; // R1
               endcase
            end
         end
         // Address, size and space settle one cycle before the strobes
         ST_ADDR: begin
            st_nxt.state = ST_WAIT;
         end
         ST_WAIT: begin
            // Hold here as wait states until a line asserts
            // Read data is taken with the acknowledge it rides on
            if (any_ack) begin // R22
               st_nxt.state = ST_END;
               if (!st_r.write) begin
                  if (moved == 3'h2) begin
                     st_nxt.rbuf = {st_r.rbuf[15:0], data_in}; // R14
                  end else if (half_ack && st_r.addr[0]) begin
                     st_nxt.rbuf = {st_r.rbuf[23:0], data_in[7:0]}; // R5 R20
                  end else begin
                     // Byte port or even byte: upper lane only
                     st_nxt.rbuf = {st_r.rbuf[23:0], data_in[15:8]}; // R6 R11
                  end
               end
               st_nxt.left = st_r.left - moved; // R12
               st_nxt.addr = st_r.addr + 24'(moved); // R12
               // Write buffer moves up by the bytes just taken
               if (moved == 3'h2) begin
                  st_nxt.wbuf = {st_r.wbuf[15:0], 16'h0000};
               end else begin
                  st_nxt.wbuf = {st_r.wbuf[23:0], 8'h00}; // R13
               end
               if (st_r.split && st_r.left == 3'h3) begin
                  st_nxt.split = 1'b0; // R18
               end
            end
         end
         ST_END: begin
            // Strobes negated; wait for the partner to release
            // A finished request pulses done once and returns to idle
            if (!any_ack) begin // R23
               if (st_r.left == CNT_RST) begin
                  st_nxt.state = ST_IDLE;
                  st_nxt.done  = 1'b1;
                  st_nxt.rdata = st_r.rbuf;
               end else begin
                  st_nxt.state = ST_ADDR; // R15
               end
            end
         end
         default: begin
            st_nxt.state = ST_IDLE;
         end
      endcase
   end

   // State register; reset gives an idle bus with strobes negated
   // The acknowledge synchroniser resets to the negated level as well
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r <= '{ST_IDLE, ADDR_RST, CNT_RST, 1'b0, 3'h0,
                   DATA_RST, DATA_RST, 1'b0, DATA_RST, 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Bus outputs follow state; strobes only between address and end
   always_comb begin
      req_ready_out          = (st_r.state == ST_IDLE);
      done_out               = st_r.done;
      rdata_out              = st_r.rdata;
      addr_out               = st_r.addr;
      transfer_size_code_out = size_of(cyc_cnt); // R2 R15 R19
      access_space_code_out  = st_r.space;
      read_not_write_out     = ~st_r.write;
      address_strobe_b_out   = ~(st_r.state == ST_WAIT);
      data_strobe_b_out      = ~(st_r.state == ST_WAIT);
      data_oe_out            = st_r.write && (st_r.state != ST_IDLE);
      // Lanes: a single byte, or any cycle at an odd address, puts the
      // same byte on both lanes so a port of either width finds it; an
      // even multi-byte cycle puts the next two bytes on the two lanes.
      if (cyc_cnt == 3'h1 || st_r.addr[0]) begin
         data_out = {st_r.wbuf[31:24], st_r.wbuf[31:24]}; // R7 R19
      end else begin
         data_out = st_r.wbuf[31:16]; // R13 R20
      end
   end
endmodule
`default_nettype wire

//--- core/bus_sizing_pkg.sv
// Constants and types for the dynamic bus sizing operand steering block
// Functional notes
// (R1) Bytes sent most significant first
// (R2) Present address, size, space, direction at start
// (R3) Byte port acks 10, upper lane
// (R4) Halfword port even byte: upper lane, ack 01
// (R5) Odd byte from halfword port: lower lane
// (R6) Byte port reads: capture upper lane only
// (R7) Byte writes replicate onto both lanes
// (R8) Byte port stores upper lane, then acks
// (R9) Odd halfword write takes lower lane
// (R10) Byte-writable halfword memory uses two banks
// (R11) Byte port ignores address LSB
// (R12) After byte ack: count down, address up
// (R13) Word write to byte port: shift low byte up
// (R14) Aligned long to halfword continues as word
// (R15) Long to byte port: three-byte, word, byte
// (R16) Three-byte size only as intermediate cycle
// (R17) Misaligned word to halfword: lower lane first
// (R18) Misaligned long splits into two words
// (R19) Misaligned word to byte port: both lanes
// (R20) Surplus write lanes; ignore unused read lanes
// (R21) Acknowledge lines active low
// (R22) No ack: wait states, keep sampling
// (R23) Partner releases within one clock after strobes
`default_nettype none
package bus_sizing_pkg;
   // Transfer size codes
   localparam logic [1:0] SIZE_LONG  = 2'h0;
   localparam logic [1:0] SIZE_BYTE  = 2'h1;
   localparam logic [1:0] SIZE_WORD  = 2'h2;
   localparam logic [1:0] SIZE_THREE = 2'h3;
   // Acknowledge pair values, active low
   localparam logic [1:0] ACK_NONE   = 2'h3;
   localparam logic [1:0] ACK_BYTE   = 2'h2;
   localparam logic [1:0] ACK_HALF   = 2'h1;
   // Reset values
   localparam logic [23:0] ADDR_RST  = 24'h000000;
   localparam logic [31:0] DATA_RST  = 32'h00000000;
   localparam logic [2:0]  CNT_RST   = 3'h0;
   // Bus sequencer states
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ADDR  = 2'b01,
      ST_WAIT  = 2'b10,
      ST_END   = 2'b11
   } bus_state_t;
endpackage
`default_nettype wire

//--- tb/bus_sizing_props.sv
// Checker on the bus sizing master's ports
`timescale 1ns/1ps
`default_nettype none
module bus_sizing_props
   import bus_sizing_pkg::*;
(
   // Clock, reset and request side
   input wire logic        clock_in,
   input wire logic        rst_b_in,
   input wire logic        req_valid_in,
   input wire logic        req_ready_out,
   input wire logic [23:0] req_addr_in,
   input wire logic [1:0]  req_size_in,
   input wire logic [31:0] req_wdata_in,
   input wire logic        req_write_in,
   input wire logic [2:0]  req_space_in,
   // External bus
   input wire logic [23:0] addr_out,
   input wire logic [1:0]  transfer_size_code_out,
   input wire logic        read_not_write_out,
   input wire logic        address_strobe_b_out,
   input wire logic        data_strobe_b_out,
   input wire logic [2:0]  access_space_code_out,
   input wire logic        data_oe_out,
   input wire logic [15:0] data_out,
   input wire logic [1:0]  port_width_ack_pair_in
);
   logic        fst_r; // First bus cycle not yet acked
   logic [1:0]  sz_r;  // Held request size
   logic [23:0] ad_r;  // Held request address
   logic [31:0] wd_r;  // Held write data
   logic [2:0]  sp_r;  // Held access space
   logic        wt_r;  // Held direction
   logic        bus;   // Bus cycle running
   logic        wr;    // Write cycle running
   assign bus = !address_strobe_b_out;
   assign wr  = bus && !read_not_write_out;
   // First-cycle marker, dropped once the first cycle's strobe rises
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) fst_r <= 1'b0;
      else if (req_valid_in && req_ready_out) fst_r <= 1'b1;
      else if ($rose(address_strobe_b_out)) fst_r <= 1'b0;
   end
   // Request fields kept for the whole transfer
   always_ff @(posedge clock_in) begin
      if (req_valid_in && req_ready_out) begin
         sz_r <= req_size_in;
         ad_r <= req_addr_in;
         wd_r <= req_wdata_in;
         sp_r <= req_space_in;
         wt_r <= req_write_in;
      end
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   first_cycle_a: assert property (
      $fell(address_strobe_b_out) && fst_r |-> addr_out == ad_r &&
      transfer_size_code_out == ((sz_r == SIZE_LONG && ad_r[0]) ?
      SIZE_WORD : sz_r)) else $error("first cycle address or size");
   busy_ready_a: assert property (bus |-> !req_ready_out)
      else $error("ready while bus busy");
   byte_replica_a: assert property (
      wr && transfer_size_code_out == SIZE_BYTE |->
      data_out[15:8] == data_out[7:0]) else $error("byte not on both");
   odd_word_a: assert property (
      wr && transfer_size_code_out == SIZE_WORD && addr_out[0] |->
      data_out[15:8] == data_out[7:0]) else $error("odd word lanes");
   word_lanes_a: assert property (
      wr && fst_r && sz_r == SIZE_WORD && !ad_r[0] |->
      data_out == wd_r[15:0]) else $error("word lanes");
   low_byte_up_a: assert property (
      wr && !fst_r && sz_r == SIZE_WORD && !ad_r[0] |->
      data_out[15:8] == wd_r[7:0]) else $error("low byte not moved up");
   three_byte_a: assert property (
      bus && transfer_size_code_out == SIZE_THREE |->
      addr_out[0] && sz_r == SIZE_LONG) else $error("three-byte misuse");
   wait_hold_a: assert property (
      (bus && port_width_ack_pair_in == ACK_NONE)[*5] |=> bus)
      else $error("cycle ended without ack");
   split_sizes_a: assert property (
      bus && sz_r == SIZE_LONG && ad_r[0] |-> transfer_size_code_out ==
      (addr_out[0] ? SIZE_WORD : SIZE_BYTE)) else $error("split size");
   cycle_attrs_a: assert property (
      bus |-> access_space_code_out == sp_r && read_not_write_out == !wt_r
      && data_oe_out == wt_r && !data_strobe_b_out)
      else $error("cycle attributes");
   three_c: cover property (bus && transfer_size_code_out == SIZE_THREE);
   split_c: cover property (bus && sz_r == SIZE_LONG && ad_r[0] &&
      transfer_size_code_out == SIZE_BYTE);
   half_c: cover property (bus && port_width_ack_pair_in == ACK_HALF);
   wait_c: cover property ((bus && port_width_ack_pair_in == ACK_NONE)[*5]);
endmodule
bind bus_sizing_master bus_sizing_props u_props (.*);
`default_nettype wire

//--- tb/dynamic_bus_sizing_operand_steering_tb.sv
// Self-checking bench for the bus sizing master
`timescale 1ns/1ps
`default_nettype none
module dynamic_bus_sizing_operand_steering_tb;
   import bus_sizing_pkg::*;
   logic        clock_in, rst_b_in, req_valid_in, req_write_in;
   logic        req_ready_out, done_out, read_not_write_out;
   logic        data_oe_out, address_strobe_b_out, data_strobe_b_out;
   logic [23:0] req_addr_in, addr_out;
   logic [1:0]  req_size_in, transfer_size_code_out;
   logic [1:0]  port_width_ack_pair_in;
   logic [2:0]  req_space_in, access_space_code_out;
   logic [31:0] req_wdata_in, rdata_out;
   logic [15:0] data_out, data_in;
   logic        wide; // Port is 16 bits wide
   logic [3:0]  lat;  // Port wait states
   int          errors, checks_done;
   bus_sizing_master u_dut (.*);
   sized_port_model u_port (.clock_in(clock_in), .wide_in(wide),
      .lat_in(lat), .addr_in(addr_out), .size_in(transfer_size_code_out),
      .rnw_in(read_not_write_out), .as_b_in(address_strobe_b_out),
      .wdata_in(data_out), .data_out(data_in),
      .ack_out(port_width_ack_pair_in));
   initial begin
      clock_in = 1'b0;
      forever #4 clock_in = ~clock_in;
   end
   task automatic tally_and_finish;
      if (errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // One request; a read compares its result with d
   task automatic go(input logic [23:0] a, input logic [1:0] s,
                     input logic w, input logic [31:0] d);
      int n;
      req_addr_in  <= a;
      req_size_in  <= s;
      req_write_in <= w;
      req_space_in <= a[2:0];
      req_wdata_in <= d;
      req_valid_in <= 1'b1;
      @(posedge clock_in);
      while (req_ready_out !== 1'b1) @(posedge clock_in);
      req_valid_in <= 1'b0;
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (done_out !== 1'b1 && n < 900);
      checks_done++;
      if (done_out !== 1'b1 || (!w && rdata_out !== d)) begin
         $display("Error rdata_out expected %h seen %h", d, rdata_out);
         errors++;
      end
   endtask
   // Byte and word traffic on a byte-wide port
   task automatic narrow_port;
      go(24'h3, SIZE_BYTE, 1'b1, 32'h5a);
      go(24'h2, SIZE_BYTE, 1'b1, 32'ha5);
      go(24'h2, SIZE_WORD, 1'b0, 32'ha55a);
      go(24'h5, SIZE_WORD, 1'b1, 32'h1234);
      go(24'h6, SIZE_BYTE, 1'b0, 32'h34);
      go(24'h6, SIZE_WORD, 1'b1, 32'hbeef);
      go(24'h5, SIZE_WORD, 1'b0, 32'h12be);
   endtask
   // Long words on a slow byte-wide port
   task automatic long_narrow;
      lat <= 4'h5;
      go(24'h8, SIZE_LONG, 1'b1, 32'ha1b2c3d4);
      go(24'h8, SIZE_LONG, 1'b0, 32'ha1b2c3d4);
      go(24'hb, SIZE_BYTE, 1'b0, 32'hd4);
   endtask
   // Halfword port, aligned and misaligned; last long read back on byte port
   task automatic wide_port;
      wide <= 1'b1;
      lat  <= 4'h2;
      go(24'h8, SIZE_LONG, 1'b0, 32'ha1b2c3d4);
      go(24'h1, SIZE_BYTE, 1'b1, 32'h77);
      go(24'h1, SIZE_BYTE, 1'b0, 32'h77);
      go(24'h3, SIZE_WORD, 1'b1, 32'h9abc);
      go(24'h4, SIZE_BYTE, 1'b0, 32'hbc);
      go(24'h9, SIZE_LONG, 1'b1, 32'h0f1e2d3c);
      wide <= 1'b0;
      go(24'h9, SIZE_LONG, 1'b0, 32'h0f1e2d3c);
   endtask
   initial begin
      rst_b_in     = 1'b0;
      req_valid_in = 1'b0;
      req_write_in = 1'b0;
      req_addr_in  = 24'h0;
      req_size_in  = SIZE_BYTE;
      req_space_in = 3'h0;
      req_wdata_in = 32'h0;
      wide         = 1'b0;
      lat          = 4'h0;
      errors       = 0;
      checks_done  = 0;
      repeat (5) @(posedge clock_in);
      rst_b_in <= 1'b1;
      narrow_port();
      long_narrow();
      wide_port();
      tally_and_finish();
   end
   // Watchdog: ample for some twenty transfers
   initial begin
      #200000;
      errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire

//--- tb/sized_port_model.sv
// External port model, byte-wide or halfword-wide
`timescale 1ns/1ps
`default_nettype none
module sized_port_model (
   // Clock and bus from the master
   input  wire logic        clock_in,
   input  wire logic        wide_in,
   input  wire logic [3:0]  lat_in,
   input  wire logic [23:0] addr_in,
   input  wire logic [1:0]  size_in,
   input  wire logic        rnw_in,
   input  wire logic        as_b_in,
   input  wire logic [15:0] wdata_in,
   // Answer
   output logic      [15:0] data_out,
   output logic      [1:0]  ack_out
);
   logic [7:0] mem [0:15]; // Two byte banks, interleaved
   logic [3:0] cnt;        // Wait states served
   logic [3:0] a;          // Location addressed
   logic [3:0] ev;         // Even location of the pair
   assign a  = addr_in[3:0];
   assign ev = {a[3:1], 1'b0};
   initial begin
      cnt      = 4'h0;
      ack_out  = 2'h3;
      data_out = 16'h0;
   end
   // One answer per cycle; released data toggles, never holds
   always @(posedge clock_in) begin
      if (as_b_in) begin
         cnt      <= 4'h0;
         ack_out  <= 2'h3;
         data_out <= ~data_out;
      end else if (cnt < lat_in) begin
         cnt <= cnt + 4'h1;
      end else if (cnt == lat_in) begin
         cnt     <= cnt + 4'h1;
         ack_out <= wide_in ? 2'h1 : 2'h2;
         if (rnw_in) begin
            data_out <= wide_in ? {mem[ev], mem[ev | 4'h1]}
                                : {mem[a], ~mem[a]};
         end else if (!wide_in || !a[0]) begin
            mem[a] <= wdata_in[15:8];
            if (wide_in && size_in != 2'h1) mem[a + 4'h1] <= wdata_in[7:0];
         end else begin
            mem[a] <= wdata_in[7:0];
         end
      end
   end
endmodule
`default_nettype wire
